// [src/subtract_exec_regs.vh]
// Register offsets, field positions, reset values and opcodes of the subtract/sleep unit
`ifndef SUBTRACT_EXEC_REGS_VH
`define SUBTRACT_EXEC_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ADDR_INSTR 8'h00
`define ADDR_ACCUM 8'h04
`define ADDR_FILE 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_WAKE 8'h10
`define ADDR_WDOG 8'h14

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define ST_CARRY 0
`define ST_DIGIT 1
`define ST_ZERO 2
`define ST_OVFL 3
`define ST_TIMEOUT 4
`define ST_PWRDN 5
`define ST_ASLEEP 6
`define ST_BUSY 7

// ----------------------------------------
// Wake register field positions
// ----------------------------------------
`define WAKE_WDOG 0
`define WAKE_OTHER 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_BYTE 8'h00
`define RST_INSTR 16'h0000
`define RST_TIMEOUT 1'b1
`define RST_PWRDN 1'b1

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_LIT_HI 8'hB2
`define OP_SUB_HI7 7'h02
`define OP_SUBB_HI7 7'h01
`define OP_SLEEP 16'h0003
`define DEST_BIT 8

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [src/sub_borrow_unit.v]
// Eight-bit subtractor with carry, digit carry, overflow and zero flags
`timescale 1ns/100ps
module sub_borrow_unit (
   input wire [7:0] minuend,
   input wire [7:0] subtrahend,
   input wire carry_in,
   output wire [7:0] diff,
   output wire carry_out,
   output wire digit_carry,
   output wire overflow,
   output wire zero
);
   // Two's complement: a + ~b + cin; carry out high means no borrow
   wire [8:0] full_sum;
   wire [4:0] low_sum;

   assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
   assign low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
   assign diff = full_sum[7:0];
   assign carry_out = full_sum[8];
   assign digit_carry = low_sum[4];
   assign overflow = (minuend[7] ^ subtrahend[7]) & (full_sum[7] ^ minuend[7]);
   assign zero = (full_sum[7:0] == 8'h00);
endmodule

// [src/subtract_sleep_exec.v]
// Subtract and low-power instruction execution unit with an AXI4-Lite register slave
//
// Operation
// - Upper byte B2 decodes literal subtract; lower byte is the literal.
// - Literal subtract: literal minus accumulator, result into the accumulator.
// - Literal subtract changes only overflow, carry, digit carry and zero.
// - Carry set when result is zero or positive, cleared on borrow.
// - Underflow wraps as eight-bit two's complement; minus one gives FF.
// - Pattern 0000 010d: file register minus accumulator, two's complement.
// - Destination bit 0 writes accumulator, 1 writes the file register.
// - Waking by watchdog timeout clears the timeout flag.
// - Sleep clears powerdown, sets timeout, clears watchdog and postscaler, stops clock.
// - Word 0003 is the operand-free sleep instruction.
`include "subtract_exec_regs.vh"
`timescale 1ns/100ps
module subtract_sleep_exec (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg osc_stopped
);
   // ----------------------------------------
   // Phases
   // ----------------------------------------
   localparam [2:0] PH_IDLE = 3'h0;
   localparam [2:0] PH_DECODE = 3'h1;
   localparam [2:0] PH_READ = 3'h2;
   localparam [2:0] PH_EXEC = 3'h3;
   localparam [2:0] PH_WRITE = 3'h4;

   localparam [2:0] CLS_NONE = 3'h0;
   localparam [2:0] CLS_LIT = 3'h1;
   localparam [2:0] CLS_SUB = 3'h2;
   localparam [2:0] CLS_SUBB = 3'h3;
   localparam [2:0] CLS_SLEEP = 3'h4;

   // ----------------------------------------
   // State
   // ----------------------------------------
   reg [2:0] phase_q;
   reg [2:0] cls_q;
   reg [15:0] instr_q;
   reg [7:0] working_accumulator_q;
   reg [7:0] file_q;
   reg carry_q;
   reg digit_carry_flag_q;
   reg zero_q;
   reg overflow_flag_q;
   reg timeout_flag_q;
   reg powerdown_flag_q;
   reg [7:0] watchdog_counter_q;
   reg [7:0] postscaler_q;
   reg [7:0] op_a_q;
   reg [7:0] op_b_q;
   reg op_cin_q;
   reg [7:0] res_q;
   reg res_c_q;
   reg res_dc_q;
   reg res_ov_q;
   reg res_z_q;
   reg [7:0] aw_addr_q;
   reg aw_full_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg w_full_q;

   wire aw_hs;
   wire w_hs;
   wire ar_hs;
   wire do_write;
   wire [7:0] alu_diff;
   wire alu_c;
   wire alu_dc;
   wire alu_ov;
   wire alu_z;
   wire [7:0] status_word;
   reg [31:0] rd_word;
   reg rd_ok;
   reg wr_ok;

   assign aw_hs = s_axi_awvalid & s_axi_awready;
   assign w_hs = s_axi_wvalid & s_axi_wready;
   assign ar_hs = s_axi_arvalid & s_axi_arready;
   assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid;

   assign status_word = {(phase_q != PH_IDLE), osc_stopped, powerdown_flag_q, timeout_flag_q,
                         overflow_flag_q, zero_q, digit_carry_flag_q, carry_q};

   // ----------------------------------------
   // Subtractor
   // ----------------------------------------
   sub_borrow_unit alu (
      .minuend(op_a_q),
      .subtrahend(op_b_q),
      .carry_in(op_cin_q),
      .diff(alu_diff),
      .carry_out(alu_c),
      .digit_carry(alu_dc),
      .overflow(alu_ov),
      .zero(alu_z)
   );

   // ----------------------------------------
   // Read decode
   // ----------------------------------------
   always @* begin
      rd_word = 32'h00000000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `ADDR_INSTR: rd_word = {16'h0000, instr_q};
         `ADDR_ACCUM: rd_word = {24'h000000, working_accumulator_q};
         `ADDR_FILE: rd_word = {24'h000000, file_q};
         `ADDR_STATUS: rd_word = {24'h000000, status_word};
         `ADDR_WAKE: rd_word = 32'h00000000;
         `ADDR_WDOG: rd_word = {16'h0000, postscaler_q, watchdog_counter_q};
         default: rd_ok = 1'b0;
      endcase
   end

   always @* begin
      case (aw_addr_q)
         `ADDR_INSTR, `ADDR_ACCUM, `ADDR_FILE, `ADDR_STATUS, `ADDR_WAKE, `ADDR_WDOG: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Bus slave and execution
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         s_axi_bvalid <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         osc_stopped <= 1'b0;
         aw_addr_q <= `RST_BYTE;
         aw_full_q <= 1'b0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         w_full_q <= 1'b0;
         phase_q <= PH_IDLE;
         cls_q <= CLS_NONE;
         instr_q <= `RST_INSTR;
         working_accumulator_q <= `RST_BYTE;
         file_q <= `RST_BYTE;
         carry_q <= 1'b0;
         digit_carry_flag_q <= 1'b0;
         zero_q <= 1'b0;
         overflow_flag_q <= 1'b0;
         timeout_flag_q <= `RST_TIMEOUT;
         powerdown_flag_q <= `RST_PWRDN;
         watchdog_counter_q <= `RST_BYTE;
         postscaler_q <= `RST_BYTE;
         op_a_q <= `RST_BYTE;
         op_b_q <= `RST_BYTE;
         op_cin_q <= 1'b0;
         res_q <= `RST_BYTE;
         res_c_q <= 1'b0;
         res_dc_q <= 1'b0;
         res_ov_q <= 1'b0;
         res_z_q <= 1'b0;
      end else begin
         // Address and data are held until both have arrived
         s_axi_awready <= ~aw_hs & ~aw_full_q;
         s_axi_wready <= ~w_hs & ~w_full_q;
         s_axi_arready <= ~ar_hs & ~s_axi_rvalid;
         if (aw_hs) begin
            aw_addr_q <= s_axi_awaddr;
            aw_full_q <= 1'b1;
         end
         if (w_hs) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_full_q <= 1'b1;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (ar_hs) begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            s_axi_rvalid <= 1'b1;
         end

         // Watchdog runs only while the clock is running and stays cleared once sleep executes
         if (!osc_stopped && !(phase_q == PH_WRITE && cls_q == CLS_SLEEP)) begin
            watchdog_counter_q <= watchdog_counter_q + 8'h01;
            if (watchdog_counter_q == 8'hFF) begin
               postscaler_q <= postscaler_q + 8'h01;
            end
         end

         // Software writes; hardware updates below take priority
         if (do_write) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            case (aw_addr_q)
               `ADDR_INSTR: begin
                  // Ignored while busy or asleep
                  if (phase_q == PH_IDLE && !osc_stopped && w_strb_q[1:0] == 2'h3) begin
                     instr_q <= w_data_q[15:0];
                     phase_q <= PH_DECODE;
                  end
               end
               `ADDR_ACCUM: begin
                  if (w_strb_q[0]) begin
                     working_accumulator_q <= w_data_q[7:0];
                  end
               end
               `ADDR_FILE: begin
                  if (w_strb_q[0]) begin
                     file_q <= w_data_q[7:0];
                  end
               end
               `ADDR_STATUS: begin
                  if (w_strb_q[0]) begin
                     carry_q <= w_data_q[`ST_CARRY];
                     digit_carry_flag_q <= w_data_q[`ST_DIGIT];
                     zero_q <= w_data_q[`ST_ZERO];
                     overflow_flag_q <= w_data_q[`ST_OVFL];
                  end
               end
               `ADDR_WAKE: begin
                  if (w_strb_q[0] && osc_stopped) begin
                     if (w_data_q[`WAKE_WDOG]) begin
                        osc_stopped <= 1'b0;
                        timeout_flag_q <= 1'b0;
                     end else if (w_data_q[`WAKE_OTHER]) begin
                        osc_stopped <= 1'b0;
                     end
                  end
               end
               default: begin
               end
            endcase
         end

         // Four-phase instruction cycle
         case (phase_q)
            PH_IDLE: begin
            end
            PH_DECODE: begin
               if (instr_q[15:8] == `OP_LIT_HI) begin
                  cls_q <= CLS_LIT;
               end else if (instr_q[15:9] == `OP_SUB_HI7) begin
                  cls_q <= CLS_SUB;
               end else if (instr_q[15:9] == `OP_SUBB_HI7) begin
                  cls_q <= CLS_SUBB;
               end else if (instr_q == `OP_SLEEP) begin
                  cls_q <= CLS_SLEEP;
               end else begin
                  cls_q <= CLS_NONE;
               end
               phase_q <= PH_READ;
            end
            PH_READ: begin
               op_a_q <= (cls_q == CLS_LIT) ? instr_q[7:0] : file_q;
               op_b_q <= working_accumulator_q;
               op_cin_q <= (cls_q == CLS_SUBB) ? carry_q : 1'b1;
               phase_q <= PH_EXEC;
            end
            PH_EXEC: begin
               res_q <= alu_diff;
               res_c_q <= alu_c;
               res_dc_q <= alu_dc;
               res_ov_q <= alu_ov;
               res_z_q <= alu_z;
               if (cls_q == CLS_SLEEP) begin
                  powerdown_flag_q <= 1'b0;
                  timeout_flag_q <= 1'b1;
                  watchdog_counter_q <= `RST_BYTE;
                  postscaler_q <= `RST_BYTE;
               end
               phase_q <= PH_WRITE;
            end
            PH_WRITE: begin
               if (cls_q == CLS_LIT || cls_q == CLS_SUB || cls_q == CLS_SUBB) begin
                  carry_q <= res_c_q;
                  digit_carry_flag_q <= res_dc_q;
                  overflow_flag_q <= res_ov_q;
                  zero_q <= res_z_q;
                  if (cls_q != CLS_LIT && instr_q[`DEST_BIT]) begin
                     file_q <= res_q;
                  end else begin
                     working_accumulator_q <= res_q;
                  end
               end
               if (cls_q == CLS_SLEEP) begin
                  osc_stopped <= 1'b1;
               end
               phase_q <= PH_IDLE;
            end
            default: phase_q <= PH_IDLE;
         endcase
      end
   end
endmodule

// [tb/subtract_sleep_exec_chk.sv]
// Bus and sleep timing checker for the subtract and sleep unit
`timescale 1ns/100ps
module subtract_sleep_exec_chk (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire osc_stopped
);
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire aw_t = s_axi_awvalid && s_axi_awready;
   wire wr_t = aw_t && s_axi_wvalid && s_axi_wready;
   wire ar_t = s_axi_arvalid && s_axi_arready;
   wire ins_t = wr_t && s_axi_awaddr == 8'h00 && s_axi_wstrb[1:0] == 2'h3;
   reg [3:0] gap_q;
   reg [3:0] wk_q;
   always @(posedge aclk) begin
      if (!aresetn) begin
         gap_q <= 4'hF;
         wk_q <= 4'h0;
      end else begin
         gap_q <= ins_t ? 4'h0 : (gap_q == 4'hF ? gap_q : gap_q + 4'h1);
         wk_q <= {wk_q[2:0], wr_t && s_axi_awaddr == 8'h10};
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   b_timing_a: assert property (wr_t |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   r_timing_a: assert property (ar_t |-> ##[1:2] s_axi_rvalid)
      else $error("read data late");
   rd_err_a: assert property (ar_t && s_axi_araddr > 8'h17 |-> ##[1:2]
      (s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0))
      else $error("unmapped read not refused");
   wr_err_a: assert property (wr_t && s_axi_awaddr > 8'h17 |-> ##[1:2]
      (s_axi_bvalid && s_axi_bresp == 2'h2))
      else $error("unmapped write not refused");
   aw_drop_a: assert property (aw_t |=> !s_axi_awready)
      else $error("address ready held after take");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("address ready during read answer");
   sleep_stop_a: assert property (ins_t && s_axi_wdata[15:0] == 16'h0003
      && gap_q == 4'hF && !osc_stopped |-> !osc_stopped [*3] ##[1:4] osc_stopped)
      else $error("sleep did not stop the oscillator on time");
   stay_asleep_a: assert property ($fell(osc_stopped) |-> wk_q != 4'h0)
      else $error("oscillator restarted without a wake write");
endmodule
bind subtract_sleep_exec subtract_sleep_exec_chk i_chk (.*);

// [tb/host_model.sv]
// Register bus host model that issues reads and writes
`timescale 1ns/100ps
module host_model (
   input wire aclk,
   output reg [7:0] s_axi_awaddr = 8'h00,
   output reg [2:0] s_axi_awprot = 3'h0,
   output reg s_axi_awvalid = 1'b0,
   input wire s_axi_awready,
   output reg [31:0] s_axi_wdata = 32'h0,
   output reg [3:0] s_axi_wstrb = 4'h0,
   output reg s_axi_wvalid = 1'b0,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   output reg s_axi_bready = 1'b0,
   output reg [7:0] s_axi_araddr = 8'h00,
   output reg [2:0] s_axi_arprot = 3'h0,
   output reg s_axi_arvalid = 1'b0,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   output reg s_axi_rready = 1'b0
);
   // ----------------------------------------
   // Bus tasks; released payloads are inverted
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
      logic ad;
      logic wd;
      begin
         s_axi_awaddr <= a;
         s_axi_awprot <= 3'($urandom);
         s_axi_wdata <= v;
         s_axi_wstrb <= s;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         ad = 1'b0;
         wd = 1'b0;
         while (!(ad && wd)) begin
            @(posedge aclk);
            if (s_axi_awready && !ad) begin
               s_axi_awvalid <= 1'b0;
               s_axi_awaddr <= ~a;
               ad = 1'b1;
            end
            if (s_axi_wready && !wd) begin
               s_axi_wvalid <= 1'b0;
               s_axi_wdata <= ~v;
               wd = 1'b1;
            end
         end
         repeat ($urandom % 3) @(posedge aclk);
         s_axi_bready <= 1'b1;
         do @(posedge aclk); while (!s_axi_bvalid);
         s_axi_bready <= 1'b0;
      end
   endtask
   task automatic rd(input logic [7:0] a);
      begin
         s_axi_araddr <= a;
         s_axi_arprot <= 3'($urandom);
         s_axi_arvalid <= 1'b1;
         do @(posedge aclk); while (!s_axi_arready);
         s_axi_arvalid <= 1'b0;
         s_axi_araddr <= ~a;
         repeat ($urandom % 3) @(posedge aclk);
         s_axi_rready <= 1'b1;
         do @(posedge aclk); while (!s_axi_rvalid);
         s_axi_rready <= 1'b0;
      end
   endtask
endmodule

// [tb/subtract_sleep_exec_test.sv]
// Self-checking bench for the subtract and sleep unit
`timescale 1ns/100ps
`include "subtract_exec_regs.vh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module subtract_sleep_exec_test;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   wire [7:0] s_axi_awaddr, s_axi_araddr;
   wire [2:0] s_axi_awprot, s_axi_arprot;
   wire [31:0] s_axi_wdata, s_axi_rdata;
   wire [3:0] s_axi_wstrb;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, osc_stopped;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   logic [31:0] rq[$];
   logic [1:0] bq[$];
   logic [3:0] fl;
   logic [31:0] rexp;
   logic [1:0] bexp;
   subtract_sleep_exec i_dut (.*);
   host_model i_host (.*);
   // ----------------------------------------
   // Clock, timeout and result monitor
   // ----------------------------------------
   initial forever #10 aclk = ~aclk;
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
      // Take each note off once, so a mismatch cannot consume the next one
      if (s_axi_rvalid && s_axi_rready) begin
         rexp = rq.pop_front();
         `CHK(s_axi_rdata, rexp)
      end
      if (s_axi_bvalid && s_axi_bready) begin
         bexp = bq.pop_front();
         `CHK(s_axi_bresp, bexp)
      end
   end
   task automatic end_sim;
      begin
         $display("compares %0d failures %0d", compares, failures);
         if (failures == 0 && compares > 0) begin
            $display("All checks passed");
         end else begin
            $display("Checks failed");
         end
         $finish;
      end
   endtask
   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
      bq.push_back(r);
      i_host.wr(a, v, 4'hF);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] v);
      rq.push_back(v);
      i_host.rd(a);
   endtask
   function automatic logic [11:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic ci);
      logic [8:0] s;
      logic [4:0] h;
      begin
         s = {1'b0, a} + {1'b0, ~b} + {8'h0, ci};
         h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ci};
         return {s[7:0], (a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
      end
   endfunction
   task automatic step(input int op, input logic [7:0] w, input logic [7:0] f,
      input logic c, input logic d);
      logic [11:0] e;
      logic [15:0] ins;
      begin
         wr(`ADDR_ACCUM, {24'h0, w}, `RESP_OKAY);
         wr(`ADDR_FILE, {24'h0, f}, `RESP_OKAY);
         wr(`ADDR_STATUS, {31'h0, c}, `RESP_OKAY);
         e = sub8(f, w, op == 2 ? c : 1'b1);
         ins = op == 0 ? {`OP_LIT_HI, f} : {op == 1 ? `OP_SUB_HI7 : `OP_SUBB_HI7, d, 8'h2A};
         wr(`ADDR_INSTR, {16'h0, ins}, `RESP_OKAY);
         repeat (4) @(posedge aclk);
         fl = e[3:0];
         rd(`ADDR_ACCUM, {24'h0, (op == 0 || !d) ? e[11:4] : w});
         rd(`ADDR_FILE, {24'h0, (op != 0 && d) ? e[11:4] : f});
         rd(`ADDR_STATUS, {24'h0, 4'h3, fl});
      end
   endtask
   initial begin
      void'($urandom(32'hB64F6D82));
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`ADDR_STATUS, 32'h30);
      step(0, 8'h03, 8'h02, 1'b0, 1'b0);
      step(0, 8'h02, 8'h02, 1'b0, 1'b0);
      step(2, 8'h0E, 8'h03, 1'b1, 1'b1);
      step(2, 8'h1A, 8'h1B, 1'b0, 1'b0);
      for (int i = 0; i < 24; i++) begin
         step(i % 3, 8'($urandom), 8'($urandom), 1'($urandom), 1'($urandom));
      end
      wr(8'h18, 32'h5, `RESP_SLVERR);
      rd(8'h18, 32'h0);
      for (int b = 0; b < 2; b++) begin
         repeat (16) @(posedge aclk);
         wr(`ADDR_INSTR, 32'h3, `RESP_OKAY);
         repeat (4) @(posedge aclk);
         rd(`ADDR_STATUS, {24'h0, 4'h5, fl});
         rd(`ADDR_WDOG, 32'h0);
         wr(`ADDR_WAKE, b == 0 ? 32'h1 : 32'h2, `RESP_OKAY);
         repeat (2) @(posedge aclk);
         rd(`ADDR_STATUS, {24'h0, b == 0 ? 4'h0 : 4'h1, fl});
      end
      @(posedge aclk);
      end_sim();
   end
endmodule
